// File: cc_array_pkg.sv
// Purpose: constants and types shared by the capture/compare array
// Assumes: APB register map, 32-bit words, byte addresses
// Notes: unit b registers sit at unit a offsets plus UNIT_STRIDE
package cc_array_pkg;
    localparam int UNITS = 2;
    localparam int CH = 16;
    localparam int TB_W = 16;
    localparam int DIV_W = 10;
    // finest step in ns at the reference cpu clock, and its cycle count
    localparam int FINEST_RES_NS = 125;
    localparam int REF_CPU_MHZ = 64;
    localparam int FINEST_CYCLES = (FINEST_RES_NS * REF_CPU_MHZ) / 1000;
    localparam logic [11:0] UNIT_STRIDE = 12'h100;
    localparam logic [7:0] OFF_TB_COUNT = 8'h00;
    localparam logic [7:0] OFF_TB_RELOAD = 8'h08;
    localparam logic [7:0] OFF_TB_CTRL = 8'h10;
    localparam logic [7:0] OFF_CC_VALUE = 8'h40;
    localparam logic [7:0] OFF_CC_CTRL = 8'h80;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h200;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h204;
    localparam int TBC_W = 6;
    localparam int TBC_SEL_LSB = 0;
    localparam int TBC_SRC_LSB = 3;
    localparam int TBC_RUN_BIT = 5;
    localparam int CCC_W = 5;
    localparam int CCC_TB_BIT = 3;
    localparam int CCC_DBL_BIT = 4;
    localparam logic [TB_W-1:0] TB_RESET = 16'h0000;
    localparam logic [TB_W-1:0] TB_TOP = 16'hffff;
    localparam logic [TBC_W-1:0] TBC_RESET = 6'h00;
    localparam logic [CCC_W-1:0] CCC_RESET = 5'h00;
    typedef enum logic [2:0] {
        CC_OFF = 3'b000,
        CC_CAP_RISE = 3'b001,
        CC_CAP_FALL = 3'b010,
        CC_CAP_BOTH = 3'b011,
        CC_CMP0 = 3'b100,
        CC_CMP1 = 3'b101,
        CC_CMP2 = 3'b110,
        CC_CMP3 = 3'b111
    } cc_mode_t;
    typedef enum logic [1:0] {
        SRC_PRESCALE = 2'b00,
        SRC_TIMER_SIX = 2'b01,
        SRC_EXT_COUNT = 2'b10,
        SRC_HOLD = 2'b11
    } tb_src_t;
    typedef enum logic [2:0] {
        K_NONE = 3'b000,
        K_TB_COUNT = 3'b001,
        K_TB_RELOAD = 3'b010,
        K_TB_CTRL = 3'b011,
        K_CC_VALUE = 3'b100,
        K_CC_CTRL = 3'b101,
        K_IRQ_STAT = 3'b110,
        K_IRQ_MASK = 3'b111
    } reg_kind_t;
    typedef struct packed {
        reg_kind_t kind;
        logic [4:0] idx;
    } reg_sel_t;
endpackage

// File: dual_capture_compare_array.sv
// Purpose: two capture/compare units, each two time bases and sixteen channels
// Assumes: pclk is the cpu clock; pins and external count are synchronised here, timer six pulse is synchronous
// Notes: zero-wait APB slave; read data comes from a setup-phase flop
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps

module dual_capture_compare_array
    import cc_array_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [UNITS*CH-1:0] cc_pin_in,
    output logic [UNITS*CH-1:0] cc_pin_out,
    output logic [UNITS*CH-1:0] cc_pin_oe_n,
    input wire logic [UNITS-1:0] ext_count_in,
    input wire logic general_timer_six_ovf,
    output logic irq
);
    localparam int NCH = UNITS * CH;
    localparam int NTB = UNITS * 2;
    localparam int NIN = NCH + UNITS;

    function automatic reg_sel_t decode(input logic [11:0] a);
        reg_sel_t s;
        logic [7:0] off;
        s.kind = K_NONE;
        s.idx = 5'h00;
        off = a[7:0];
        if (a == OFF_IRQ_STATUS) begin
            s.kind = K_IRQ_STAT;
        end else if (a == OFF_IRQ_MASK) begin
            s.kind = K_IRQ_MASK;
        end else if (a[11:9] == 3'h0 && a[1:0] == 2'h0) begin
            if (off[7:3] == OFF_TB_COUNT[7:3]) begin
                s.kind = K_TB_COUNT;
                s.idx = {3'h0, a[8], off[2]};
            end else if (off[7:3] == OFF_TB_RELOAD[7:3]) begin
                s.kind = K_TB_RELOAD;
                s.idx = {3'h0, a[8], off[2]};
            end else if (off[7:3] == OFF_TB_CTRL[7:3]) begin
                s.kind = K_TB_CTRL;
                s.idx = {3'h0, a[8], off[2]};
            end else if (off[7:6] == OFF_CC_VALUE[7:6]) begin
                s.kind = K_CC_VALUE;
                s.idx = {a[8], off[5:2]};
            end else if (off[7:6] == OFF_CC_CTRL[7:6]) begin
                s.kind = K_CC_CTRL;
                s.idx = {a[8], off[5:2]};
            end
        end
        return s;
    endfunction

    // prescaler tick every (8 << sel) cycles
    function automatic logic presc_tick(input logic [DIV_W-1:0] div, input logic [2:0] sel);
        logic [DIV_W:0] m;
        m = (DIV_W+1)'(FINEST_CYCLES) << sel;
        m = m - 1'b1;
        return (div & m[DIV_W-1:0]) == m[DIV_W-1:0];
    endfunction

    reg_sel_t sel_w;
    logic access_w;
    logic wr_w;
    logic [31:0] rd_w;
    logic [31:0] prdata_q;
    logic [31:0] irq_stat_q;
    logic [31:0] irq_mask_q;
    logic [DIV_W-1:0] div_q;
    logic [NIN-1:0] sync1_q;
    logic [NIN-1:0] sync2_q;
    logic [NIN-1:0] sync3_q;
    logic [NIN-1:0] rise_w;
    logic [NIN-1:0] fall_w;
    logic [TB_W-1:0] tb_cnt_q [NTB];
    logic [TB_W-1:0] tb_rel_q [NTB];
    logic [TBC_W-1:0] tb_ctl_q [NTB];
    logic [NTB-1:0] tb_step_q;
    logic [NTB-1:0] tb_ovf_q;
    logic [TB_W-1:0] cc_val_q [NCH];
    logic [CCC_W-1:0] cc_ctl_q [NCH];
    logic [NCH-1:0] pin_q;
    logic [NCH-1:0] done_q;
    logic [NCH-1:0] fire_w;
    logic [NCH-1:0] cap_w;

    assign sel_w = decode(paddr);
    assign access_w = psel & penable;
    assign wr_w = access_w & pwrite;
    assign pready = 1'b1;
    assign pslverr = access_w & (sel_w.kind == K_NONE);
    assign prdata = prdata_q;
    assign irq = |(irq_stat_q & irq_mask_q);

    always_comb begin
        rd_w = 32'h0000_0000;
        unique case (sel_w.kind)
            K_NONE: rd_w = 32'h0000_0000;
            K_TB_COUNT: rd_w[TB_W-1:0] = tb_cnt_q[sel_w.idx[1:0]];
            K_TB_RELOAD: rd_w[TB_W-1:0] = tb_rel_q[sel_w.idx[1:0]];
            K_TB_CTRL: rd_w[TBC_W-1:0] = tb_ctl_q[sel_w.idx[1:0]];
            K_CC_VALUE: rd_w[TB_W-1:0] = cc_val_q[sel_w.idx];
            K_CC_CTRL: rd_w[CCC_W-1:0] = cc_ctl_q[sel_w.idx];
            K_IRQ_STAT: rd_w = irq_stat_q;
            K_IRQ_MASK: rd_w = irq_mask_q;
        endcase
    end

    // read data is latched in the setup cycle so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_w;
        end
    end

    // clear only the bits software saw, so a set in between is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 32'h0000_0000;
        end else if (access_w && !pwrite && sel_w.kind == K_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~prdata_q) | (fire_w | cap_w);
        end else begin
            irq_stat_q <= irq_stat_q | fire_w | cap_w;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= 32'h0000_0000;
        end else if (wr_w && sel_w.kind == K_IRQ_MASK) begin
            irq_mask_q <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= {ext_count_in, cc_pin_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // edges look only at the second and third flops
    assign rise_w = sync2_q & ~sync3_q;
    assign fall_w = ~sync2_q & sync3_q;

    genvar t;
    generate
        for (t = 0; t < NTB; t++) begin : g_tb
            logic tick;
            logic step;
            logic ovf;
            logic wr_cnt;
            tb_src_t src;
            assign src = tb_src_t'(tb_ctl_q[t][TBC_SRC_LSB +: 2]);
            assign wr_cnt = wr_w && sel_w.kind == K_TB_COUNT && sel_w.idx[1:0] == t;
            always_comb begin
                tick = 1'b0;
                unique case (src)
                    SRC_PRESCALE: tick = presc_tick(div_q, tb_ctl_q[t][TBC_SEL_LSB +: 3]);
                    SRC_TIMER_SIX: tick = general_timer_six_ovf;
                    // external count, first time base of each unit only
                    SRC_EXT_COUNT: tick = ((t % 2) == 0) ? rise_w[NCH + t/2] : 1'b0;
                    SRC_HOLD: tick = 1'b0;
                endcase
            end
            assign step = tb_ctl_q[t][TBC_RUN_BIT] & tick;
            assign ovf = step & (tb_cnt_q[t] == TB_TOP);
            // count up, reload past the top
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tb_cnt_q[t] <= TB_RESET;
                end else if (wr_cnt) begin
                    tb_cnt_q[t] <= pwdata[TB_W-1:0];
                end else if (ovf) begin
                    tb_cnt_q[t] <= tb_rel_q[t];
                end else if (step) begin
                    tb_cnt_q[t] <= tb_cnt_q[t] + 1'b1;
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tb_step_q[t] <= 1'b0;
                    tb_ovf_q[t] <= 1'b0;
                end else begin
                    tb_step_q[t] <= step & ~wr_cnt;
                    tb_ovf_q[t] <= ovf & ~wr_cnt;
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    tb_rel_q[t] <= TB_RESET;
                    tb_ctl_q[t] <= TBC_RESET;
                end else if (wr_w && sel_w.idx[1:0] == t) begin
                    if (sel_w.kind == K_TB_RELOAD) begin
                        tb_rel_q[t] <= pwdata[TB_W-1:0];
                    end
                    if (sel_w.kind == K_TB_CTRL) begin
                        tb_ctl_q[t] <= pwdata[TBC_W-1:0];
                    end
                end
            end
        end
    endgenerate

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_cc
            localparam int U = c / CH;
            localparam int I = c % CH;
            localparam int PART = (I < 8) ? c + 8 : c - 8;
            cc_mode_t mode;
            logic [1:0] tb;
            logic match;
            logic once;
            logic dbl_own;
            logic dbl_part;
            logic drive;
            logic toggle;
            logic set_hi;
            logic wr_val;
            assign mode = cc_mode_t'(cc_ctl_q[c][2:0]);
            assign tb = {U[0], cc_ctl_q[c][CCC_TB_BIT]};
            assign once = (mode == CC_CMP2) || (mode == CC_CMP3);
            assign match = mode[2] & tb_step_q[tb] & (tb_cnt_q[tb] == cc_val_q[c]);
            assign fire_w[c] = match & ~(once & done_q[c] & ~tb_ovf_q[tb]);
            assign cap_w[c] = ((mode == CC_CAP_RISE) & rise_w[c]) |
                              ((mode == CC_CAP_FALL) & fall_w[c]) |
                              ((mode == CC_CAP_BOTH) & (rise_w[c] | fall_w[c]));
            assign dbl_own = (I < 8) & cc_ctl_q[c][CCC_DBL_BIT];
            assign dbl_part = (I >= 8) & cc_ctl_q[PART][CCC_DBL_BIT];
            // either register of the pair toggles the low pin
            assign toggle = dbl_own ? (fire_w[c] | fire_w[PART]) :
                            (~dbl_part & (mode == CC_CMP1) & fire_w[c]);
            assign set_hi = ~dbl_own & ~dbl_part & (mode == CC_CMP3) & fire_w[c];
            // pin is output only in pin-driving compare modes or as the low pin of a double pair
            assign drive = ~dbl_part & (dbl_own | mode == CC_CMP1 | mode == CC_CMP3);
            assign cc_pin_oe_n[c] = ~drive;
            assign cc_pin_out[c] = pin_q[c];
            assign wr_val = wr_w && sel_w.kind == K_CC_VALUE && sel_w.idx == c;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cc_val_q[c] <= TB_RESET;
                end else if (cap_w[c]) begin
                    cc_val_q[c] <= tb_cnt_q[tb];
                end else if (wr_val) begin
                    cc_val_q[c] <= pwdata[TB_W-1:0];
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cc_ctl_q[c] <= CCC_RESET;
                end else if (wr_w && sel_w.kind == K_CC_CTRL && sel_w.idx == c) begin
                    cc_ctl_q[c] <= pwdata[CCC_W-1:0];
                end
            end
            // one event per period, rearmed by overflow
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    done_q[c] <= 1'b0;
                end else if (fire_w[c]) begin
                    done_q[c] <= 1'b1;
                end else if (tb_ovf_q[tb] || !once) begin
                    done_q[c] <= 1'b0;
                end
            end
            // pin update, match after overflow wins
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_q[c] <= 1'b0;
                end else if (set_hi) begin
                    pin_q[c] <= 1'b1;
                end else if (toggle) begin
                    pin_q[c] <= ~pin_q[c];
                end else if (mode == CC_CMP3 && tb_ovf_q[tb] && !dbl_own && !dbl_part) begin
                    pin_q[c] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

// File: cc_array_asserts.sv
// Purpose: port-level checks for the capture/compare array
// Assumes: zero-wait apb slave, one clock domain
// Notes: sees the top-level ports only
`timescale 1ns/100ps
module cc_array_asserts
    import cc_array_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [UNITS*CH-1:0] cc_pin_oe_n,
    input wire logic irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable;
    endsequence
    sequence s_rd_err;
        (psel && !penable && !pwrite) ##1 (psel && penable && pslverr);
    endsequence
    a_pready_tied: assert property (pready) else $error("pready low");
    a_err_unaligned: assert property (s_acc ##0 (paddr[1:0] != 2'b00) |-> pslverr)
        else $error("unaligned access accepted");
    a_err_hole: assert property (s_acc ##0 (paddr == 12'h300) |-> pslverr)
        else $error("unmapped access accepted");
    a_err_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error outside access");
    a_reset_pins: assert property ($rose(presetn) |-> &cc_pin_oe_n)
        else $error("pin driven out of reset");
    a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    a_err_rdata: assert property (s_rd_err |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_oe_after_wr: assert property ($changed(cc_pin_oe_n) |-> $past(psel && penable && pwrite))
        else $error("pin direction moved without a write");
    a_irq_reset: assert property ($rose(presetn) |-> !irq)
        else $error("interrupt raised out of reset");
endmodule
bind dual_capture_compare_array cc_array_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cc_pin_oe_n(cc_pin_oe_n), .irq(irq));

// File: cc_pin_model.sv
// Purpose: far-side pin model for the capture/compare array
// Assumes: pins have no pull, the bench supplies input levels
// Notes: a driven pin reads back what its channel puts on it
`timescale 1ns/100ps
module cc_pin_model (
    input wire logic [31:0] drive_val,
    input wire logic [31:0] drive_oe_n,
    input wire logic [31:0] stim,
    output logic [31:0] pin_in
);
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            pin_in[i] = drive_oe_n[i] ? stim[i] : drive_val[i];
        end
    end
endmodule

// File: test_dual_capture_compare_array.sv
// Purpose: self-checking bench for the capture/compare array
// Assumes: timer six pulses and pin levels come from the bench
// Notes: count model tracks the count write and timer six step of each tick
`timescale 1ns/100ps
module test_dual_capture_compare_array;
    import cc_array_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, six = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd_q, v, stim = '0, pin_out, oe_n, pin_in;
    logic pready, pslverr, irq, err_q;
    logic [1:0] ext = '0;
    logic [15:0] d16;
    int err_count = 0, checked = 0, cnt = 0, rel = 0, c0;
    int ch_tab[6] = '{0, 1, 2, 3, 4, 11};
    logic [31:0] md_tab[6] = '{32'h4, 32'h6, 32'h7, 32'h15, 32'h5, 32'h5};
    dual_capture_compare_array dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cc_pin_in(pin_in),
        .cc_pin_out(pin_out), .cc_pin_oe_n(oe_n), .ext_count_in(ext),
        .general_timer_six_ovf(six), .irq(irq));
    cc_pin_model pins (.drive_val(pin_out), .drive_oe_n(oe_n), .stim(stim), .pin_in(pin_in));
    initial forever #2.5 pclk = ~pclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one transfer plus an idle cycle, so psel is never set twice in a step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic tick(input int load, input logic [31:0] st, input logic [2:0] pin);
        apb(1'b1, 12'h000, load);
        cnt = load;
        six <= 1'b1;
        @(posedge pclk);
        six <= 1'b0;
        cnt = (cnt == 65535) ? rel : cnt + 1;
        repeat (4) @(posedge pclk);
        chk(irq, st[0]);
        apb(1'b0, 12'h200, 0);
        chk(rd_q, st);
        apb(1'b0, 12'h000, 0);
        chk(rd_q, cnt);
        chk(irq, 0);
        chk(pin_out[4:2], pin);
    endtask
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h0f05529d));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h010, 0);
        chk(rd_q, TBC_RESET);
        apb(1'b0, 12'h300, 0);
        chk(err_q, 1'b1);
        chk(rd_q, 32'h0);
        apb(1'b0, 12'h002, 0);
        chk(err_q, 1'b1);
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, 12'h010, 32'h20 | s);
            apb(1'b0, 12'h000, 0);
            v = rd_q;
            repeat ((16 << s) - 3) @(posedge pclk);
            apb(1'b0, 12'h000, 0);
            d16 = rd_q[15:0] - v[15:0];
            chk(d16, 16'h2);
        end
        apb(1'b1, 12'h010, 32'h28);
        c0 = $urandom_range(16'hf000, 16'h0100);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 12'(64 + 4 * ch_tab[i]), c0 + (i == 5));
            apb(1'b1, 12'(128 + 4 * ch_tab[i]), md_tab[i]);
        end
        chk({oe_n[11], oe_n[4:0]}, 6'b100011);
        apb(1'b1, 12'h204, 32'h1);
        tick(c0 - 1, 32'h1f, 3'b111);
        tick(c0, 32'h800, 3'b101);
        tick(c0 - 1, 32'h19, 3'b011);
        tick(65535, 32'h0, 3'b010);
        tick(c0 - 1, 32'h1f, 3'b101);
        apb(1'b1, 12'h010, 32'h38);
        for (int i = 5; i < 8; i++) begin
            apb(1'b1, 12'(128 + 4 * i), i - 4);
        end
        for (int p = 0; p < 2; p++) begin
            v = $urandom_range(65535, 0);
            apb(1'b1, 12'h000, v);
            stim[7:5] <= p ? 3'b000 : 3'b111;
            repeat (5) @(posedge pclk);
            apb(1'b0, 12'h200, 0);
            chk(rd_q, p ? 32'hc0 : 32'ha0);
            apb(1'b0, 12'(84 + 4 * p), 0);
            chk(rd_q, v);
            apb(1'b0, 12'h05c, 0);
            chk(rd_q, v);
        end
        for (int u = 0; u < 2; u++) begin
            apb(1'b1, 12'(u * 256 + 16), 32'h30);
            apb(1'b1, 12'(u * 256), 0);
            repeat (3) begin
                ext[u] <= 1'b1;
                repeat (2) @(posedge pclk);
                ext[u] <= 1'b0;
                repeat (2) @(posedge pclk);
            end
            repeat (4) @(posedge pclk);
            apb(1'b0, 12'(u * 256), 0);
            chk(rd_q, 32'h3);
        end
        give_verdict();
    end
endmodule
